// ### inc/ccon_consts.svh
// Purpose: Constants for the operator console control block
// Assumes: Included by bare name, once per compilation unit
// Notes: Definitions only
`ifndef CCON_CONSTS_SVH
`define CCON_CONSTS_SVH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define CCON_OFF_STW 32'h0000_0000
`define CCON_OFF_CSTAT 32'h0000_0004
`define CCON_OFF_DBUF 32'h0000_0008

// ****************************************
// Status word fields
// ****************************************
`define CCON_STW_MASK 16'hBD57
`define CCON_STW_PROG 16'h0007
`define CCON_STW_MACH 16'h0D00
`define CCON_STW_PWR 16'h8000
`define CCON_STW_AUTO 16'h2000
`define CCON_STW_RST 16'h0000

// ****************************************
// Reset values and sizes
// ****************************************
`define CCON_NKEYS 16
`define CCON_LAMPS_RST 16'hFFFF
`define CCON_DBUF_RST 16'h0000
`define CCON_SAD_RST 16'h0000
`define CCON_WORD_ZERO 16'h0000

`endif

// ### inc/ccon_pkg.sv
// Purpose: Types shared by the operator console control files
// Assumes: ccon_consts.svh on the include path
// Notes: Carriers are packed structs
package ccon_pkg;
`include "ccon_consts.svh"

    typedef enum logic [1:0] {CCON_MODE_NORMAL, CCON_MODE_AUTO, CCON_MODE_DIAG} ccon_mode_t;
    typedef enum logic [1:0] {ST_STOP, ST_RUN, ST_WAIT, ST_LOAD} ccon_state_t;
    typedef enum logic [2:0] {DS_ALLON, DS_BUF, DS_MSG, DS_IAD, DS_RES} ccon_disp_t;

    typedef struct packed {
        logic [3:0] level;
        logic res;
        logic entry;
        logic store;
        logic soe;
        logic crst;
        logic step;
        logic sad;
        logic data_buf;
        logic stop;
        logic start;
        logic reset;
        logic load;
    } ccon_keys_t;

    typedef struct packed {
        ccon_keys_t keys;
        ccon_mode_t mode;
        logic prog_attached;
        logic [3:0] nibble;
    } ccon_panel_t;

    typedef struct packed {
        logic instr_done;
        logic exit_wait;
        logic wake;
        logic stop_instr;
        logic iad_loaded;
        logic [15:0] iad;
        logic [1:0] level;
        logic [15:0] stw_set;
        logic stw_clear;
        logic summary_mask;
        logic lights_wr;
        logic [15:0] lights_data;
        logic pld_done;
        logic power_ok;
        logic disp_err;
        logic [15:0] res_data;
    } ccon_core_in_t;

    typedef struct packed {
        logic exec_en;
        logic in_wait;
        logic sys_reset;
        logic pld_start;
        logic restart_zero;
        logic take_class;
        logic store_req;
        logic level_sel_valid;
        logic [1:0] level_sel;
    } ccon_core_out_t;

    typedef struct packed {
        logic [15:0] data;
        logic [3:0] level;
        logic run;
        logic wait_l;
        logic load;
        logic stop;
        logic check;
        logic sad;
        logic step;
        logic crst;
        logic soe;
    } ccon_lamps_t;
endpackage

// ### rtl/ccon_key_sync.sv
// Purpose: Synchronise panel keys and turn each press into a pulse
// Assumes: Keys are active high levels held for several cycles
// Notes: Pulse comes on the rising edge of the second stage
`timescale 1ns/1ps
`default_nettype none
module ccon_key_sync #(
    parameter int W = 16
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [W-1:0] key_raw,
    output logic [W-1:0] key_pulse
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_key
            always_ff @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    s1_q[i] <= 1'b0;
                    s2_q[i] <= 1'b0;
                    s3_q[i] <= 1'b0;
                end else begin
                    s1_q[i] <= key_raw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
            assign key_pulse[i] = s2_q[i] & ~s3_q[i];
        end
    endgenerate
endmodule // ccon_key_sync
`default_nettype wire

// ### rtl/ccon_apb_slave.sv
// Purpose: APB slave for the console registers
// Assumes: Zero wait states; 32-bit aligned words
// Notes: Unmapped access answers with pslverr
`timescale 1ns/1ps
`default_nettype none
module ccon_apb_slave
    import ccon_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] stw,
    input wire logic [15:0] cstat,
    input wire logic [15:0] dbuf,
    output logic dbuf_wr,
    output logic [15:0] dbuf_wdata
);
    logic [31:0] prdata_q;
    wire hit_stw = (paddr == `CCON_OFF_STW);
    wire hit_cstat = (paddr == `CCON_OFF_CSTAT);
    wire hit_dbuf = (paddr == `CCON_OFF_DBUF);
    wire mapped = hit_stw | hit_cstat | hit_dbuf;
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire [15:0] rd_mux = hit_stw ? stw : hit_cstat ? cstat : hit_dbuf ? dbuf : `CCON_WORD_ZERO;

    // Read data captured in setup so it stands through the access cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata_q <= {16'h0000, rd_mux};
        end
    end

    assign prdata = prdata_q;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign dbuf_wr = access & pwrite & hit_dbuf;
    assign dbuf_wdata = pwdata[15:0];
endmodule // ccon_apb_slave
`default_nettype wire

// ### rtl/ccon_console.sv
// Purpose: Operator console control: processor state, modes, lamps
// Assumes: Core and panel share ref_clk; core reports instruction events
// Notes: Registers reached over APB through ccon_apb_slave
//
// Decided for this implementation: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Load key resets, loads, lamp until done
// - Auto mode loads after power-on, sets bit13
// - Stop instruction only stops in diagnostic mode
// - Wait lamp after level exit, nothing pending
// - Run lamp only while executing
// - Run/wait shows buffer; lights message persists
// - Entering stop shows instruction address
// - Buffer kept; data buffer key redisplays
// - Power-on: data lamps on, levels off
// - Check lamp on errors, cleared by keys
// - Storage display error lights check lamp
// - Active level lamp; level keys select
// - All listed causes enter stop state
// - Address stop and step exclusive
// - Address stop key toggles its mode
// - Step key toggles step, stops running
// - Step start runs one instruction
// - Compare address stored in stop; stop on match
// - Check restart and error stop exclusive
// - Check restart restarts at zero, level zero
// - Error stop; start continues class interrupt
// - Status word bit layout, unused zero
// - Start resumes, or returns to wait
module ccon_console
    import ccon_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ccon_pkg::ccon_panel_t panel,
    input wire ccon_pkg::ccon_core_in_t core_in,
    output var ccon_pkg::ccon_core_out_t core_out,
    output var ccon_pkg::ccon_lamps_t lamps,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import ccon_pkg::*;

    function automatic logic [3:0] lvl_onehot(input logic [1:0] lvl);
        lvl_onehot = 4'h1 << lvl;
    endfunction

    // ****************************************
    // Key pulses
    // ****************************************
    logic [`CCON_NKEYS-1:0] key_pulse;
    ccon_keys_t kp;

    ccon_key_sync #(.W(`CCON_NKEYS)) u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .key_raw(panel.keys),
        .key_pulse(key_pulse)
    );
    assign kp = ccon_keys_t'(key_pulse);

    // ****************************************
    // State and mode registers
    // ****************************************
    ccon_state_t state_q, state_d;
    ccon_disp_t disp_q, disp_d;
    logic stop_pend_q, step_run_q, from_wait_q, class_pend_q;
    logic sad_q, step_q, crst_q, soe_q, check_q, lvl_on_q;
    logic [15:0] stw_q, dbuf_q, sad_buf_q, msg_q, lamp_data_q;
    logic [1:0] lvl_q;
    logic sys_reset_q, pld_start_q, restart_q, take_class_q, store_req_q, lvl_sel_v_q;
    logic dbuf_wr;
    logic [15:0] dbuf_wdata;

    wire is_stop = (state_q == ST_STOP);
    wire is_run = (state_q == ST_RUN);
    wire is_wait = (state_q == ST_WAIT);
    wire is_load = (state_q == ST_LOAD);
    wire any_key = |key_pulse;
    wire lvl_key = |kp.level;
    wire [1:0] lvl_key_num = kp.level[3] ? 2'd3 : kp.level[2] ? 2'd2 : kp.level[1] ? 2'd1 : 2'd0;

    // ****************************************
    // Event decode
    // ****************************************
    wire diag_eff = (panel.mode == CCON_MODE_DIAG) && panel.prog_attached;
    wire auto_pld = core_in.power_ok && (panel.mode == CCON_MODE_AUTO);
    wire load_go = kp.load | auto_pld;
    wire [15:0] err_mask = `CCON_STW_PROG | `CCON_STW_MACH
                         | (core_in.summary_mask ? `CCON_STW_PWR : `CCON_WORD_ZERO);
    wire err_evt = (|(core_in.stw_set & err_mask)) && (is_run || is_wait);
    wire crst_evt = err_evt && crst_q;
    wire soe_evt = err_evt && soe_q;
    wire sad_hit = sad_q && is_run && core_in.iad_loaded
                 && (core_in.iad == sad_buf_q);
    wire instr_stop = is_run && core_in.stop_instr && diag_eff;
    wire end_stop = is_run && core_in.instr_done && (stop_pend_q || step_run_q);
    wire step_set = kp.step && !step_q;
    wire start_go = kp.start && is_stop;
    wire sys_reset = kp.reset | kp.load;

    // ****************************************
    // Processor state machine
    // ****************************************
    always_comb begin
        state_d = state_q;
        if (kp.reset) begin
            state_d = ST_STOP;
        end else if (load_go) begin
            state_d = ST_LOAD;
        end else if (soe_evt) begin
            state_d = ST_STOP;
        end else begin
            unique case (state_q)
                ST_LOAD: begin
                    if (core_in.pld_done) begin
                        state_d = ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (sad_hit || instr_stop || end_stop) begin
                        state_d = ST_STOP;
                    end else if (core_in.exit_wait) begin
                        state_d = ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (kp.stop) begin
                        state_d = ST_STOP;
                    end else if (core_in.wake) begin
                        state_d = ST_RUN;
                    end
                end
                ST_STOP: begin
                    if (kp.start) begin
                        if (from_wait_q && !step_q && !class_pend_q) begin
                            state_d = ST_WAIT;
                        end else begin
                            state_d = ST_RUN;
                        end
                    end
                end
            endcase
        end
    end

    wire stop_enter = (state_d == ST_STOP) && (!is_stop || kp.reset);
    wire leave_stop = is_stop && (state_d != ST_STOP);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_STOP;
        end else begin
            state_q <= state_d;
        end
    end

    // Stop key and step selection in run wait for the instruction to finish
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_pend_q <= 1'b0;
            step_run_q <= 1'b0;
        end else begin
            stop_pend_q <= !stop_enter && !load_go
                         && (stop_pend_q || (is_run && (kp.stop || step_set)));
            step_run_q <= !stop_enter && !load_go
                        && (step_run_q || (start_go && step_q));
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            from_wait_q <= 1'b0;
            class_pend_q <= 1'b0;
        end else begin
            from_wait_q <= (stop_enter && is_wait && !kp.reset)
                         || (from_wait_q && !leave_stop && !sys_reset);
            class_pend_q <= soe_evt
                          || (class_pend_q && !start_go && !sys_reset);
        end
    end

    // ****************************************
    // Mode keys
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sad_q <= 1'b0;
            step_q <= 1'b0;
            crst_q <= 1'b0;
            soe_q <= 1'b0;
        end else begin
            if (kp.sad) begin
                sad_q <= !sad_q;
                step_q <= step_q && sad_q;
            end else if (kp.step) begin
                step_q <= !step_q;
                sad_q <= sad_q && step_q;
            end
            if (kp.crst) begin
                crst_q <= !crst_q;
                soe_q <= soe_q && crst_q;
            end else if (kp.soe) begin
                soe_q <= !soe_q;
                crst_q <= crst_q && soe_q;
            end
        end
    end

    // ****************************************
    // Check lamp and status word
    // ****************************************
    wire check_set = err_evt || (core_in.disp_err && is_stop);
    wire check_clr = sys_reset || core_in.stw_clear || (any_key && is_stop);
    wire stw_clr = sys_reset || core_in.stw_clear;
    wire [15:0] stw_set = core_in.stw_set | (auto_pld ? `CCON_STW_AUTO : `CCON_WORD_ZERO);
    wire [15:0] stw_d = ((stw_clr ? `CCON_STW_RST : stw_q) | stw_set) & `CCON_STW_MASK;

    // Set wins over any clear in the same cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            check_q <= 1'b0;
            stw_q <= `CCON_STW_RST;
        end else begin
            check_q <= check_set || (check_q && !check_clr);
            stw_q <= stw_d;
        end
    end

    // ****************************************
    // Console data buffer and compare address
    // ****************************************
    wire [15:0] dbuf_d = kp.entry ? {dbuf_q[11:0], panel.nibble}
                       : dbuf_wr ? dbuf_wdata : dbuf_q;
    wire sad_store = kp.store && is_stop && sad_q;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            dbuf_q <= `CCON_DBUF_RST;
            sad_buf_q <= `CCON_SAD_RST;
        end else begin
            dbuf_q <= dbuf_d;
            if (sad_store) begin
                sad_buf_q <= dbuf_q;
            end
        end
    end

    // ****************************************
    // Level selection
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lvl_q <= 2'd0;
            lvl_on_q <= 1'b0;
        end else begin
            lvl_on_q <= lvl_on_q || any_key || core_in.instr_done || !is_stop;
            if (sys_reset) begin
                lvl_q <= 2'd0;
            end else if (is_stop && lvl_key) begin
                lvl_q <= lvl_key_num;
            end else if (!is_stop) begin
                lvl_q <= core_in.level;
            end
        end
    end

    // ****************************************
    // Display selection
    // ****************************************
    always_comb begin
        disp_d = disp_q;
        if (kp.data_buf || kp.entry) begin
            disp_d = DS_BUF;
        end else if (stop_enter) begin
            disp_d = DS_IAD;
        end else if (is_stop && (kp.res || lvl_key)) begin
            disp_d = DS_RES;
        end else if (leave_stop || (is_load && core_in.pld_done)) begin
            disp_d = DS_BUF;
        end else if (is_run && core_in.lights_wr) begin
            disp_d = DS_MSG;
        end
    end

    wire [15:0] lamp_mux = (disp_d == DS_ALLON) ? `CCON_LAMPS_RST
                         : (disp_d == DS_BUF) ? dbuf_d
                         : (disp_d == DS_MSG) ? msg_q
                         : (disp_d == DS_IAD) ? core_in.iad
                         : core_in.res_data;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            disp_q <= DS_ALLON;
            msg_q <= `CCON_WORD_ZERO;
            lamp_data_q <= `CCON_LAMPS_RST;
        end else begin
            disp_q <= disp_d;
            if (is_run && core_in.lights_wr) begin
                msg_q <= core_in.lights_data;
            end
            lamp_data_q <= (is_run && core_in.lights_wr && disp_d == DS_MSG)
                         ? core_in.lights_data : lamp_mux;
        end
    end

    // ****************************************
    // Pulses to the core
    // ****************************************
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sys_reset_q <= 1'b0;
            pld_start_q <= 1'b0;
            restart_q <= 1'b0;
            take_class_q <= 1'b0;
            store_req_q <= 1'b0;
            lvl_sel_v_q <= 1'b0;
        end else begin
            sys_reset_q <= sys_reset;
            pld_start_q <= load_go && !kp.reset;
            restart_q <= crst_evt;
            take_class_q <= start_go && class_pend_q;
            store_req_q <= kp.store && is_stop && !sad_q;
            lvl_sel_v_q <= is_stop && lvl_key;
        end
    end

    assign core_out.exec_en = is_run;
    assign core_out.in_wait = is_wait;
    assign core_out.sys_reset = sys_reset_q;
    assign core_out.pld_start = pld_start_q;
    assign core_out.restart_zero = restart_q;
    assign core_out.take_class = take_class_q;
    assign core_out.store_req = store_req_q;
    assign core_out.level_sel_valid = lvl_sel_v_q;
    assign core_out.level_sel = lvl_q;

    // ****************************************
    // Lamps
    // ****************************************
    assign lamps.data = lamp_data_q;
    assign lamps.level = lvl_on_q ? lvl_onehot(lvl_q) : 4'h0;
    assign lamps.run = is_run;
    assign lamps.wait_l = is_wait;
    assign lamps.load = is_load;
    assign lamps.stop = is_stop;
    assign lamps.check = check_q;
    assign lamps.sad = sad_q;
    assign lamps.step = step_q;
    assign lamps.crst = crst_q;
    assign lamps.soe = soe_q;

    // ****************************************
    // Register bus
    // ****************************************
    wire [15:0] cstat = {stop_pend_q, class_pend_q, from_wait_q, lamps.level,
                         is_load, is_wait, is_run, is_stop, check_q,
                         soe_q, crst_q, step_q, sad_q};

    ccon_apb_slave u_apb (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .stw(stw_q),
        .cstat(cstat),
        .dbuf(dbuf_q),
        .dbuf_wr(dbuf_wr),
        .dbuf_wdata(dbuf_wdata)
    );
endmodule // ccon_console
`default_nettype wire

// ### test/ccon_console_properties.sv
// Purpose: Assertions on console lamps and core handshakes
// Assumes: Bound to ccon_console, one clock domain
// Notes: Sees only the top module ports
`timescale 1ns/1ps
`default_nettype none
module ccon_console_properties (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire ccon_pkg::ccon_core_in_t core_in,
    input wire ccon_pkg::ccon_core_out_t core_out,
    input wire ccon_pkg::ccon_lamps_t lamps
);
    import ccon_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_lvl; $onehot0(lamps.level); endproperty
    a_lvl: assert property (p_lvl) else $error("level lamps not one-hot");
    property p_sad_step; !(lamps.sad && lamps.step); endproperty
    a_sad_step: assert property (p_sad_step) else $error("address stop and step");
    property p_crst_soe; !(lamps.crst && lamps.soe); endproperty
    a_crst_soe: assert property (p_crst_soe) else $error("restart and error stop");
    property p_run; lamps.run |-> core_out.exec_en && !lamps.stop && !lamps.wait_l; endproperty
    a_run: assert property (p_run) else $error("run lamp with other state");
    property p_pld; lamps.load && core_in.pld_done |=> lamps.run && !lamps.load; endproperty
    a_pld: assert property (p_pld) else $error("load did not end in run");
    property p_step; lamps.step && lamps.run && core_in.instr_done |=> lamps.stop; endproperty
    a_step: assert property (p_step) else $error("step ran past one instruction");
    property p_chk; core_in.disp_err && lamps.stop |=> lamps.check; endproperty
    a_chk: assert property (p_chk) else $error("display error left check dark");
    property p_show; $rose(lamps.stop) |=> lamps.data == $past(core_in.iad); endproperty
    a_show: assert property (p_show) else $error("stop entry not showing address");
    property p_crst; lamps.crst && lamps.run && (|(core_in.stw_set & 16'h0D07))
        |=> core_out.restart_zero; endproperty
    a_crst: assert property (p_crst) else $error("check restart not issued");
    property p_pon; $rose(reset_n) |-> lamps.data == 16'hFFFF && lamps.level == 4'h0; endproperty
    a_pon: assert property (p_pon) else $error("power-on lamps wrong");
endmodule // ccon_console_properties
bind ccon_console ccon_console_properties u_props(
    .ref_clk, .reset_n, .core_in, .core_out, .lamps);
`default_nettype wire

// ### test/ccon_panel_model.sv
// Purpose: Operator panel model: keys, switches, hex digit
// Assumes: Caller is just past a rising edge
// Notes: Keys idle low between presses
`timescale 1ns/1ps
`default_nettype none
module ccon_panel_model (
    input wire logic ref_clk,
    output var ccon_pkg::ccon_panel_t panel
);
    import ccon_pkg::*;
    initial panel = '0;
    task automatic press(ccon_keys_t k, logic [3:0] n = 4'h0);
        @(posedge ref_clk);
        panel.nibble <= n;
        panel.keys <= k;
        repeat (4) @(posedge ref_clk);
        panel.keys <= '0;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic set_mode(ccon_mode_t m, logic att);
        @(posedge ref_clk);
        panel.mode <= m;
        panel.prog_attached <= att;
    endtask
endmodule // ccon_panel_model
`default_nettype wire

// ### test/tb_operator_console_control.sv
// Purpose: Self-checking bench for the console control block
// Assumes: Results are APB reads checked from a queue
// Notes: Seed 71713, xorshift
`timescale 1ns/1ps
`default_nettype none
module tb_operator_console_control;
    import ccon_pkg::*;
    logic ref_clk, pready, pslverr;
    logic reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rnd = 32'h0001_1821;
    logic [63:0] e;
    logic [63:0] q[$];
    ccon_panel_t panel;
    ccon_core_in_t ci = '0;
    ccon_core_out_t co;
    ccon_lamps_t lamps;
    int err_total = 0, cmp_count = 0;
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    ccon_panel_model u_pm(.ref_clk, .panel);
    ccon_console u_dut(.ref_clk, .reset_n, .panel, .core_in(ci), .core_out(co), .lamps,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic complete_run();
        $display("cmp_count=%0d err_total=%0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            err_total++;
            complete_run();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task automatic rd(logic [31:0] a, logic [31:0] x, logic [31:0] m = 32'hFFFF_FFFF);
        q.push_back({x, m});
        apb(1'b0, a, 32'h0);
    endtask
    task automatic cp(ccon_core_in_t v);
        @(posedge ref_clk);
        ci <= v;
        @(posedge ref_clk);
        ci <= '0;
        repeat (2) @(posedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        if (psel && penable && pready) chk(pslverr, paddr > 32'h8);
        if (psel && penable && pready && !pwrite && q.size() > 0) begin
            e = q.pop_front();
            chk(prdata & e[31:0], e[63:32]);
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(32'h4, 32'h20);
        rd(32'h0, 32'h0);
        rnd = xs(rnd);
        apb(1'b1, 32'h8, rnd);
        rd(32'h8, {16'h0, rnd[15:0]});
        apb(1'b1, 32'h0, rnd);
        rd(32'h0, 32'h0);
        rd(32'h10, 32'h0);
        $display("test regs done");
        u_pm.press('{load: 1'b1, default: '0});
        rd(32'h4, 32'h100, 32'h1E0);
        cp('{pld_done: 1'b1, default: '0});
        rd(32'h4, 32'h40, 32'h1F0);
        cp('{stop_instr: 1'b1, default: '0});
        rd(32'h4, 32'h40, 32'h60);
        u_pm.set_mode(CCON_MODE_DIAG, 1'b1);
        cp('{stop_instr: 1'b1, default: '0});
        rd(32'h4, 32'h20, 32'h60);
        cp('{disp_err: 1'b1, default: '0});
        rd(32'h4, 32'h30, 32'h30);
        u_pm.set_mode(CCON_MODE_NORMAL, 1'b0);
        u_pm.press('{start: 1'b1, default: '0});
        cp('{exit_wait: 1'b1, default: '0});
        rd(32'h4, 32'h80, 32'hF0);
        u_pm.press('{stop: 1'b1, default: '0});
        rd(32'h4, 32'h2020, 32'h20E0);
        u_pm.press('{start: 1'b1, default: '0});
        rd(32'h4, 32'h80, 32'hE0);
        cp('{wake: 1'b1, default: '0});
        $display("test load and wait done");
        u_pm.press('{step: 1'b1, default: '0});
        cp('{instr_done: 1'b1, default: '0});
        rd(32'h4, 32'h22, 32'hEF);
        u_pm.press('{start: 1'b1, default: '0});
        cp('{instr_done: 1'b1, default: '0});
        rd(32'h4, 32'h22, 32'hEF);
        u_pm.press('{sad: 1'b1, default: '0});
        rd(32'h4, 32'h21, 32'hEF);
        rnd = xs(rnd);
        for (int i = 0; i < 4; i++) u_pm.press('{entry: 1'b1, default: '0}, rnd[4*(3-i)+:4]);
        rd(32'h8, {16'h0, rnd[15:0]});
        u_pm.press('{store: 1'b1, default: '0});
        u_pm.press('{start: 1'b1, default: '0});
        cp('{iad_loaded: 1'b1, iad: rnd[15:0], default: '0});
        rd(32'h4, 32'h21, 32'hEF);
        u_pm.press('{sad: 1'b1, default: '0});
        rd(32'h4, 32'h20, 32'hEF);
        $display("test step and address stop done");
        u_pm.press('{crst: 1'b1, default: '0});
        rd(32'h4, 32'h4, 32'hF);
        u_pm.press('{soe: 1'b1, default: '0});
        rd(32'h4, 32'h8, 32'hF);
        u_pm.press('{start: 1'b1, default: '0});
        cp('{stw_set: 16'hFFFF, default: '0});
        rd(32'h4, 32'h30, 32'hF0);
        rd(32'h0, 32'hBD57);
        cp('{stw_clear: 1'b1, default: '0});
        rd(32'h4, 32'h20, 32'h30);
        u_pm.press('{start: 1'b1, default: '0});
        rd(32'h4, 32'h40, 32'h60);
        u_pm.press('{crst: 1'b1, default: '0});
        cp('{stw_set: 16'h0001, default: '0});
        rd(32'h4, 32'h44, 32'h6F);
        u_pm.set_mode(CCON_MODE_AUTO, 1'b0);
        cp('{power_ok: 1'b1, default: '0});
        cp('{pld_done: 1'b1, default: '0});
        rd(32'h0, 32'h2000, 32'h2000);
        $display("test errors and auto load done");
        complete_run();
    end
endmodule // tb_operator_console_control
`default_nettype wire
